// ---- src/chh_host.sv ----
`default_nettype none
module chh_host (
    // Clocks and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic              strobe_clk,
    input  wire logic              strobe_rst_n,
    // User side
    input  wire chh_pkg::chh_mode_type mode,
    input  wire logic              req_valid,
    input  wire chh_pkg::chh_req_type  req,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output chh_pkg::chh_rsp_type   rsp,
    output logic                   dma_word_valid,
    output logic [15:0]            dma_word,
    output logic                   port16,
    output logic                   wprot,
    // Card pins
    output logic                   card_sel_n,
    output logic                   region_sel_n,
    output logic                   rd_n,
    output logic                   wr_n,
    output logic                   dma_ack_n,
    output logic [10:0]            addr,
    input  wire logic [15:0]       data_in,
    output logic [15:0]            data_out,
    output logic                   data_oe,
    input  wire logic              wait_n,
    input  wire logic              ready,
    input  wire logic              dma_wr_ready_n,
    input  wire logic              wp_pin,
    input  wire logic              cs16_n
);
    import chh_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers: three stages, change taken when stages 2 and 3 agree
    localparam int NSYNC = 4;
    logic [NSYNC-1:0] pin_raw;                 // Raw pins
    logic [NSYNC-1:0] pin_s1, pin_s2, pin_s3;  // Sync stages
    logic [NSYNC-1:0] pin_q;                   // Filtered value
    assign pin_raw = {cs16_n, wp_pin, dma_wr_ready_n, wait_n};

    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : g_sync
            // Per-pin synchroniser and agreement filter
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    pin_s1[g] <= 1'b1;
                    pin_s2[g] <= 1'b1;
                    pin_s3[g] <= 1'b1;
                    pin_q[g]  <= 1'b1;
                end else if (clk_en) begin
                    pin_s1[g] <= pin_raw[g];
                    pin_s2[g] <= pin_s1[g];
                    pin_s3[g] <= pin_s2[g];
                    if (pin_s2[g] == pin_s3[g]) begin
                        pin_q[g] <= pin_s3[g];
                    end
                end
            end
        end
    endgenerate

    // Ready has its own synchroniser (active high, rests low)
    logic rdy_s1, rdy_s2, rdy_s3, rdy_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdy_s1 <= 1'b0;
            rdy_s2 <= 1'b0;
            rdy_s3 <= 1'b0;
            rdy_q  <= 1'b0;
        end else if (clk_en) begin
            rdy_s1 <= ready;
            rdy_s2 <= rdy_s1;
            rdy_s3 <= rdy_s2;
            if (rdy_s2 == rdy_s3) begin
                rdy_q <= rdy_s3;
            end
        end
    end

    logic wait_q, wrrdy_q, wp_q, cs16_q;  // Filtered pins
    assign wait_q  = pin_q[0];
    assign wrrdy_q = pin_q[1];
    assign wp_q    = pin_q[2];
    assign cs16_q  = pin_q[3];

    ////////////////////////////////////////////////////////////////////////////////
    // Read strobe domain: capture data on both edges
    logic [15:0] rise_data;    // Word caught on rising edge
    logic [15:0] fall_data;    // Word caught on falling edge
    logic        rise_tog;     // Toggles per rising capture
    logic        fall_tog;     // Toggles per falling capture

    // Rising edge capture
    always_ff @(posedge strobe_clk) begin
        if (!strobe_rst_n) begin
            rise_tog  <= 1'b0;
            rise_data <= CHH_DATA_RST;
        end else begin
            rise_data <= data_in;
            rise_tog  <= ~rise_tog;
        end
    end

    // Falling edge capture
    always_ff @(negedge strobe_clk) begin
        if (!strobe_rst_n) begin
            fall_tog  <= 1'b0;
            fall_data <= CHH_DATA_RST;
        end else begin
            fall_data <= data_in;
            fall_tog  <= ~fall_tog;
        end
    end

    // Toggle crossings into sys_clk
    logic [2:0] rt_sync, ft_sync;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rt_sync <= 3'h0;
            ft_sync <= 3'h0;
        end else if (clk_en) begin
            rt_sync <= {rt_sync[1:0], rise_tog};
            ft_sync <= {ft_sync[1:0], fall_tog};
        end
    end

    logic rise_evt, fall_evt;  // One pulse per captured word
    assign rise_evt = rt_sync[2] ^ rt_sync[1];
    assign fall_evt = ft_sync[2] ^ ft_sync[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Cycle sequencer
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_SETUP  = 3'h1,
        ST_STROBE = 3'h2,
        ST_WAIT   = 3'h3,
        ST_DONE   = 3'h4,
        ST_DMA    = 3'h5
    } chh_state_type;

    chh_state_type          state, next_state;
    chh_req_type            cur;         // Request in progress
    logic [CHH_CNT_W-1:0]   cnt;         // Phase counter
    logic [7:0]             words;       // DMA words left
    logic                   is_write;    // Current cycle writes
    logic                   extend;      // Card holds cycle

    assign is_write = (cur.cmd == CHH_CMD_WRITE) || (cur.cmd == CHH_CMD_CFG_WR);

    // Cycle extension per mode
    always_comb begin
        if (mode == CHH_MODE_DISK) begin
            extend = !rdy_q;
        end else begin
            extend = !wait_q;
        end
    end

    // Next state
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (req_valid) begin
                    next_state = (req.cmd == CHH_CMD_DMA_RD || req.cmd == CHH_CMD_DMA_WR) ? ST_DMA : ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (cnt == CHH_CNT_W'(CHH_SETUP_CYC - 1)) begin
                    next_state = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (cnt == CHH_CNT_W'(CHH_STROBE_CYC - 1)) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!extend) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: next_state = ST_IDLE;
            ST_DMA: begin
                if (words == 8'h00) begin
                    next_state = ST_DONE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // Phase counter, cleared on each state change
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (clk_en) begin
            cnt <= (next_state != state) ? '0 : cnt + 1'b1;
        end
    end

    // Request latch
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cur <= '0;
        end else if (clk_en && state == ST_IDLE && req_valid) begin
            cur <= req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // DMA word count and delivery
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            words          <= 8'h00;
            dma_word_valid <= 1'b0;
            dma_word       <= CHH_DATA_RST;
        end else if (clk_en) begin
            dma_word_valid <= 1'b0;
            if (state == ST_IDLE && req_valid) begin
                words <= req.count;
            end else if (state == ST_DMA && words != 8'h00) begin
                if (cur.cmd == CHH_CMD_DMA_RD && (rise_evt || fall_evt)) begin
                    // One edge per cycle assumed at 80 ns strobe period
                    dma_word_valid <= 1'b1;
                    dma_word       <= rise_evt ? rise_data : fall_data;
                    words          <= words - 8'h01;
                end else if (cur.cmd == CHH_CMD_DMA_WR && !wrrdy_q) begin
                    words <= words - 8'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            card_sel_n   <= 1'b1;
            region_sel_n <= 1'b1;
            rd_n         <= 1'b1;
            wr_n         <= 1'b1;
            dma_ack_n    <= 1'b1;
            addr         <= 11'h000;
            data_out     <= CHH_DATA_RST;
            data_oe      <= 1'b0;
        end else if (clk_en) begin
            card_sel_n   <= !(next_state inside {ST_SETUP, ST_STROBE, ST_WAIT, ST_DMA});
            // Common high in memory and disk modes; attribute, config or any I/O mode cycle low
            region_sel_n <= !(cur.attr || cur.cmd == CHH_CMD_CFG_WR || mode == CHH_MODE_IO);
            dma_ack_n    <= !(next_state == ST_DMA);
            addr         <= cur.addr;
            // Strobes held while the card extends the cycle
            rd_n <= !((next_state == ST_STROBE || next_state == ST_WAIT) && !is_write);
            // Write strobe never pulses in disk mode; I/O mode only config
            wr_n <= !((next_state == ST_STROBE || next_state == ST_WAIT) && is_write
                      && mode != CHH_MODE_DISK
                      && !(mode == CHH_MODE_IO && cur.cmd != CHH_CMD_CFG_WR));
            data_oe  <= is_write && (next_state inside {ST_SETUP, ST_STROBE, ST_WAIT});
            data_out <= cur.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Responses and status
    assign req_ready = (state == ST_IDLE);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp       <= '0;
            port16    <= 1'b0;
            wprot     <= 1'b0;
        end else if (clk_en) begin
            rsp_valid <= (state == ST_DONE);
            if (state == ST_WAIT && !extend) begin
                rsp.rdata <= data_in;
                rsp.wide  <= (mode == CHH_MODE_DISK) ? !cs16_q : !wp_q;
            end
            port16 <= (mode == CHH_MODE_DISK) ? !cs16_q : (mode == CHH_MODE_IO && !wp_q);
            wprot  <= (mode == CHH_MODE_MEM) && wp_q;
        end
    end
endmodule
`default_nettype wire

// ---- src/chh_pkg.sv ----
// Functional notes
// - Host captures data on both strobe edges
// - Memory mode write strobe writes data, config
// - I/O mode write strobe writes config only
// - Disk mode: host holds write strobe high
// - Host drives DMA acknowledge during Ultra DMA
// - Region select high common, low attribute (the host also drives it low for config writes and for every I/O mode cycle)
`default_nettype none
package chh_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    // Interface modes
    typedef enum logic [1:0] {
        CHH_MODE_MEM  = 2'h0,
        CHH_MODE_IO   = 2'h1,
        CHH_MODE_DISK = 2'h2
    } chh_mode_type;

    // Host command kinds
    typedef enum logic [2:0] {
        CHH_CMD_READ     = 3'h0,
        CHH_CMD_WRITE    = 3'h1,
        CHH_CMD_CFG_WR   = 3'h2,
        CHH_CMD_DMA_RD   = 3'h3,
        CHH_CMD_DMA_WR   = 3'h4
    } chh_cmd_type;

    // One user request
    typedef struct packed {
        chh_cmd_type  cmd;
        logic         attr;
        logic [10:0]  addr;
        logic [15:0]  wdata;
        logic [7:0]   count;
    } chh_req_type;

    // Cycle result
    typedef struct packed {
        logic [15:0]  rdata;
        logic         wide;
    } chh_rsp_type;

    // Timing: setup and strobe widths in ns at 40 MHz
    localparam int CHH_CLK_NS        = 25;
    localparam int CHH_SETUP_NS      = 30;
    localparam int CHH_STROBE_NS     = 100;
    localparam int CHH_SETUP_CYC     = (CHH_SETUP_NS + CHH_CLK_NS - 1) / CHH_CLK_NS;
    localparam int CHH_STROBE_CYC    = (CHH_STROBE_NS + CHH_CLK_NS - 1) / CHH_CLK_NS;
    localparam int CHH_CNT_W         = 4;
    localparam logic [15:0] CHH_DATA_RST = 16'h0000;
endpackage
`default_nettype wire

// ---- testbench/chh_host_assertions.sv ----
`default_nettype none
// Watches the host pins against the card's handshakes
module chh_host_assertions (
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rst_n,
    // User side
    input wire chh_pkg::chh_mode_type mode,
    input wire logic                  req_valid,
    input wire logic                  req_ready,
    input wire chh_pkg::chh_req_type  req,
    input wire logic                  rsp_valid,
    input wire logic                  port16,
    input wire logic                  wprot,
    // Card pins
    input wire logic                  card_sel_n,
    input wire logic                  region_sel_n,
    input wire logic                  rd_n,
    input wire logic                  wr_n,
    input wire logic                  dma_ack_n,
    input wire logic                  wait_n,
    input wire logic                  ready,
    input wire logic                  wp_pin,
    input wire logic                  cs16_n
);
    import chh_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    // Strobes stay down while the card stalls
    a_wait_holds_cycle: assert property ((!rd_n || !wr_n) && !wait_n && mode != CHH_MODE_DISK |=> (!rd_n || !wr_n))
        else $error("strobe released during wait");
    a_ready_holds_cycle: assert property (mode == CHH_MODE_DISK && !rd_n && !ready |=> !rd_n)
        else $error("read released while not ready");
    a_release_ends_cycle: assert property (!card_sel_n && ($rose(wait_n) || $rose(ready)) |-> ##[1:12] rsp_valid)
        else $error("cycle not finished after release");
    // Write strobe use per mode
    a_io_write_cfg: assert property (mode == CHH_MODE_IO && !wr_n |-> !region_sel_n)
        else $error("I/O write outside config space");
    a_disk_write_idle: assert property (mode == CHH_MODE_DISK |-> wr_n)
        else $error("write strobe used in disk mode");
    a_region_follows_attr: assert property (req_valid && req_ready && mode == CHH_MODE_MEM && req.cmd == CHH_CMD_READ
        |-> ##2 region_sel_n == !$past(req.attr, 2))
        else $error("region select wrong");
    a_dma_ack_clean: assert property (!dma_ack_n |-> !card_sel_n && rd_n && wr_n)
        else $error("strobe during DMA");
    // Width and protect indications
    a_mem_wp_low: assert property ((mode == CHH_MODE_MEM && !wp_pin)[*8] |-> !wprot)
        else $error("write protect flagged");
    a_io_port_wide: assert property ((mode == CHH_MODE_IO && !wp_pin)[*8] |-> port16)
        else $error("I/O wide port missed");
    a_disk_word_wide: assert property ((mode == CHH_MODE_DISK && !cs16_n)[*8] |-> port16)
        else $error("disk word cycle missed");
endmodule

bind chh_host chh_host_assertions i_chh_host_assertions (.sys_clk, .rst_n, .mode, .req_valid, .req_ready, .req,
    .rsp_valid, .port16, .wprot, .card_sel_n, .region_sel_n, .rd_n, .wr_n, .dma_ack_n, .wait_n, .ready, .wp_pin,
    .cs16_n);
`default_nettype wire

// ---- testbench/chh_card_model.sv ----
`default_nettype none
// Behavioural card on the far side of the host
module chh_card_model (
    // Host pins
    input  wire chh_pkg::chh_mode_type mode,
    input  wire logic                  rd_n,
    input  wire logic                  wr_n,
    input  wire logic                  dma_ack_n,
    // Scenario knobs
    input  wire logic [31:0]           stall,
    input  wire logic                  dma_wr,
    input  wire logic                  wide,
    input  wire logic                  run,
    input  wire logic [31:0]           words,
    // Card pins
    output var logic [15:0]            data_in,
    output var logic                   wait_n,
    output var logic                   ready,
    output var logic                   dma_wr_ready_n,
    output var logic                   wp_pin,
    output var logic                   cs16_n,
    output var logic                   strobe_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    import chh_pkg::*;
    initial begin
        data_in = 16'h0000;
        wait_n = 1'b1;
        ready = 1'b1;
        dma_wr_ready_n = 1'b1;
        strobe_clk = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Stall each access, then release so the host can finish
    always @(negedge rd_n or negedge wr_n) if (dma_ack_n && stall > 0) begin
        if (mode == CHH_MODE_DISK) ready = 1'b0;
        else wait_n = 1'b0;
        #(stall * 25 + 5);
        wait_n = 1'b1;
        ready = 1'b1;
    end
    // Read word while selected, inverted once released
    always @(rd_n) if (dma_ack_n) data_in = rd_n ? ~data_in : 16'hA5C3;
    // Free strobe only while reset needs edges
    always begin
        wait (run);
        #40 strobe_clk = ~strobe_clk;
    end
    // One word per strobe edge; strobe idles between frames
    always @(negedge dma_ack_n) if (!dma_wr) begin
        for (int k = 0; k < words; k++) begin
            #30 data_in = 16'h1000 + 16'(k);
            #10 strobe_clk = ~strobe_clk;
        end
        #40 data_in = ~data_in;
    end
    // Ready for an outgoing burst after a stall
    always @(dma_ack_n) if (!dma_ack_n && dma_wr) #(stall * 25 + 5) dma_wr_ready_n = dma_ack_n;
                        else dma_wr_ready_n = 1'b1;
    // Memory mode: protect low; I/O and disk flag wide transfers
    always @* begin
        wp_pin = (mode == CHH_MODE_IO) ? !wide : 1'b0;
        cs16_n = !(wide && mode == CHH_MODE_DISK);
    end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import chh_pkg::*;
    // Bench state
    logic sys_clk = 1'b0, rst_n = 1'b0, strobe_rst_n = 1'b0, req_valid = 1'b0, dma_wr = 1'b0, wide = 1'b0, run = 1'b1;
    chh_mode_type mode = CHH_MODE_MEM;
    chh_req_type  req = '0;
    chh_rsp_type  rsp;
    int stall = 4, words = 0, bad_count = 0, tests_run = 0, cycles = 0, wr_seen = 0, nw = 0;
    logic [15:0] wr_data, dma_word, data_in, data_out;
    logic [10:0] addr;
    logic req_ready, rsp_valid, dma_word_valid, port16, wprot, card_sel_n, region_sel_n, rd_n, wr_n, dma_ack_n;
    logic data_oe, wait_n, ready, dma_wr_ready_n, wp_pin, cs16_n, strobe_clk;

    chh_host i_chh_host (.sys_clk, .rst_n, .clk_en(1'b1), .strobe_clk, .strobe_rst_n, .mode, .req_valid, .req,
        .req_ready, .rsp_valid, .rsp, .dma_word_valid, .dma_word, .port16, .wprot, .card_sel_n, .region_sel_n, .rd_n,
        .wr_n, .dma_ack_n, .addr, .data_in, .data_out, .data_oe, .wait_n, .ready, .dma_wr_ready_n, .wp_pin, .cs16_n);
    chh_card_model i_chh_card_model (.mode, .rd_n, .wr_n, .dma_ack_n, .stall, .dma_wr, .wide, .run, .words, .data_in,
        .wait_n, .ready, .dma_wr_ready_n, .wp_pin, .cs16_n, .strobe_clk);

    ////////////////////////////////////////////////////////////////////////////////
    initial forever #12.5 sys_clk = ~sys_clk;
    // Hang guard
    always @(posedge sys_clk) if (++cycles == 4000) begin
        bad_count++;
        summarize();
    end
    // Write strobes seen and the data they carry
    always @(negedge wr_n) begin
        wr_seen++;
        wr_data = data_out;
    end
    // Host takes one word per strobe edge
    always @(negedge sys_clk) if (dma_word_valid === 1'b1) begin
        `CHK("dma_word", 16'h1000 + 16'(nw), dma_word)
        nw++;
    end

    // One request, then a bounded wait for its answer
    task automatic op(input chh_cmd_type c, input logic at, input logic [7:0] n);
        // Look at settled outputs mid-cycle, drive on the next rising edge
        @(negedge sys_clk);
        while (req_ready !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req <= '{cmd: c, attr: at, addr: 11'h200, wdata: 16'h3C96, count: n};
        @(posedge sys_clk);
        req_valid <= 1'b0;
        for (int i = 0; i < 600 && rsp_valid !== 1'b1; i++) @(negedge sys_clk);
        `CHK("rsp_valid", 1'b1, rsp_valid)
    endtask
    // Stalled memory reads, common then attribute space
    task automatic t_mem_read;
        for (int a = 0; a < 2; a++) begin
            op(CHH_CMD_READ, a[0], 8'h01);
            `CHK("rdata", 16'hA5C3, rsp.rdata)
        end
        `CHK("wprot", 1'b0, wprot)
    endtask
    // Write strobe use in each mode
    task automatic t_writes;
        op(CHH_CMD_WRITE, 1'b0, 8'h01);
        op(CHH_CMD_CFG_WR, 1'b1, 8'h01);
        `CHK("mem_writes", 2, wr_seen)
        `CHK("wr_data", 16'h3C96, wr_data)
        mode <= CHH_MODE_IO;
        op(CHH_CMD_WRITE, 1'b0, 8'h01);
        `CHK("io_data_write", 2, wr_seen)
        op(CHH_CMD_CFG_WR, 1'b0, 8'h01);
        `CHK("io_cfg_write", 3, wr_seen)
        mode <= CHH_MODE_DISK;
        op(CHH_CMD_WRITE, 1'b0, 8'h01);
        `CHK("disk_write", 3, wr_seen)
    endtask
    // I/O and disk reads with width indications
    task automatic t_io_disk;
        mode <= CHH_MODE_IO;
        wide <= 1'b1;
        op(CHH_CMD_READ, 1'b0, 8'h01);
        `CHK("io_rdata", 16'hA5C3, rsp.rdata)
        `CHK("io_port16", 1'b1, port16)
        mode <= CHH_MODE_DISK;
        stall <= 7;
        op(CHH_CMD_READ, 1'b0, 8'h01);
        `CHK("disk_rdata", 16'hA5C3, rsp.rdata)
        `CHK("disk_port16", 1'b1, port16)
        wide <= 1'b0;
        repeat (8) @(posedge sys_clk);
        `CHK("narrow_port16", 1'b0, port16)
    endtask
    // DMA read of an odd word count, then a slow DMA write
    task automatic t_dma;
        mode <= CHH_MODE_MEM;
        words <= 5;
        op(CHH_CMD_DMA_RD, 1'b0, 8'h05);
        `CHK("dma_words", 5, nw)
        dma_wr <= 1'b1;
        op(CHH_CMD_DMA_WR, 1'b0, 8'h03);
        `CHK("dma_wr_done", 1'b1, dma_ack_n)
        dma_wr <= 1'b0;
    endtask
    // Verdict
    task automatic summarize;
        if (bad_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        strobe_rst_n <= 1'b1;
        run <= 1'b0;
        t_mem_read();
        t_writes();
        t_io_disk();
        t_dma();
        summarize();
    end
endmodule
`default_nettype wire
